// ==== common/iclm_pkg.sv ====
// constants and carrier types for the input clock loss monitor
// assumes a single 40 MHz aclk and an AXI4-Lite register master
`default_nettype none
package iclm_pkg;
    localparam int NUM_IN = 2;
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

    // validation times in ms; one ms tick per count
    localparam logic [13:0] VAL_MS_00 = 14'h0002;
    localparam logic [13:0] VAL_MS_01 = 14'h0064;
    localparam logic [13:0] VAL_MS_10 = 14'h00c8;
    localparam logic [13:0] VAL_MS_11 = 14'h32c8;

    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_RSVD = 2'h1;
    localparam logic [1:0] SEL_SLOW = 2'h2;
    localparam logic [1:0] SEL_STD = 2'h3;
    localparam logic [1:0] VAL_2MS = 2'h0;

    // window = predivider times 2 (standard) or 8 (slow)
    localparam int STD_SHIFT = 1;
    localparam int SLOW_SHIFT = 3;
    localparam logic [3:0] MON_DIV_LAST = 4'h3;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PREDIV0 = 8'h04;
    localparam logic [7:0] ADDR_PREDIV1 = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_STICKY = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    localparam logic [6:0] CTRL_RST = 7'h1f;
    localparam logic [15:0] PREDIV_RST = 16'h0100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control word: bit6 hold, bits5:4 validation, 3:0 selects
    typedef struct packed {
        logic force_digital_hold;
        logic [1:0] clock_validation_time;
        logic [NUM_IN-1:0][1:0] loss_detect_select;
    } iclm_ctrl_t;
endpackage
`default_nettype wire

// ==== core/iclm_monitor.sv ====
// loss-of-signal monitor for the input clocks, AXI4-Lite registers
// assumes input clock pins asynchronous and slower than aclk / 4
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module iclm_monitor #(
    parameter int MS_CYCLES_P = iclm_pkg::MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [iclm_pkg::NUM_IN-1:0] input_clock_n,
    input wire logic [iclm_pkg::NUM_IN-1:0] freq_offset_alarm,
    output logic [iclm_pkg::NUM_IN-1:0] input_bad_pin,
    output logic summary_alarm_pin,
    output logic digital_hold_req,
    output logic hitless_switch_ok,
    output logic irq
);
    localparam int N = iclm_pkg::NUM_IN;

    typedef enum logic [2:0] {
        ST_OK = 3'h1,
        ST_LOST = 3'h2,
        ST_VALID = 3'h4
    } iclm_state_t;

    // ****************************************
    // registers
    // ****************************************
    iclm_pkg::iclm_ctrl_t ctrl_reg;
    logic [N-1:0][15:0] prediv_reg;
    logic [N-1:0] sticky_reg;
    logic [N-1:0] mask_reg;
    logic [N-1:0] loss_alarm;
    logic [N-1:0] los_raw;
    logic [N-1:0] st_valid;

    logic [7:0] aw_addr_reg;
    logic aw_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_full_reg;
    logic do_write;
    logic [31:0] wmask;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_arready = !s_axi_rvalid;
    // address and data may arrive in either order
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    logic [31:0] wr_ctrl;
    logic [31:0] wr_pd0;
    logic [31:0] wr_pd1;
    logic [31:0] wr_mask;
    assign wr_ctrl = ({25'h0, ctrl_reg} & ~wmask) | (w_data_reg & wmask);
    assign wr_pd0 = ({16'h0, prediv_reg[0]} & ~wmask)
                    | (w_data_reg & wmask);
    assign wr_pd1 = ({16'h0, prediv_reg[1]} & ~wmask)
                    | (w_data_reg & wmask);
    assign wr_mask = ({30'h0, mask_reg} & ~wmask) | (w_data_reg & wmask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= iclm_pkg::CTRL_RST;
            prediv_reg <= {N{iclm_pkg::PREDIV_RST}};
            mask_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iclm_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= iclm_pkg::RESP_OKAY;
            if (aw_addr_reg[7:2] == iclm_pkg::ADDR_CTRL[7:2]) begin
                ctrl_reg <= wr_ctrl[6:0];
            end else if (aw_addr_reg[7:2] == iclm_pkg::ADDR_PREDIV0[7:2]) begin
                prediv_reg[0] <= wr_pd0[15:0];
            end else if (aw_addr_reg[7:2] == iclm_pkg::ADDR_PREDIV1[7:2]) begin
                prediv_reg[1] <= wr_pd1[15:0];
            end else if (aw_addr_reg[7:2] == iclm_pkg::ADDR_MASK[7:2]) begin
                mask_reg <= wr_mask[N-1:0];
            end else if (aw_addr_reg[7:2] != iclm_pkg::ADDR_STICKY[7:2]
                         && aw_addr_reg[7:2] != iclm_pkg::ADDR_STATUS[7:2])
            begin
                s_axi_bresp <= iclm_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // sticky copies: a set in the clearing cycle survives
    logic [N-1:0] sticky_clr;
    assign sticky_clr = (do_write && w_strb_reg[0]
        && aw_addr_reg[7:2] == iclm_pkg::ADDR_STICKY[7:2])
        ? w_data_reg[N-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_reg <= '0;
        end else begin
            sticky_reg <= (sticky_reg & ~sticky_clr) | loss_alarm;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= iclm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= iclm_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[7:2] == iclm_pkg::ADDR_CTRL[7:2]) begin
                s_axi_rdata <= {25'h0, ctrl_reg};
            end else if (s_axi_araddr[7:2]
                         == iclm_pkg::ADDR_PREDIV0[7:2]) begin
                s_axi_rdata <= {16'h0, prediv_reg[0]};
            end else if (s_axi_araddr[7:2]
                         == iclm_pkg::ADDR_PREDIV1[7:2]) begin
                s_axi_rdata <= {16'h0, prediv_reg[1]};
            end else if (s_axi_araddr[7:2] == iclm_pkg::ADDR_STATUS[7:2]) begin
                s_axi_rdata <= {23'h0, summary_alarm_pin, digital_hold_req,
                                hitless_switch_ok, input_bad_pin, los_raw,
                                loss_alarm};
            end else if (s_axi_araddr[7:2] == iclm_pkg::ADDR_STICKY[7:2]) begin
                s_axi_rdata <= {30'h0, sticky_reg};
            end else if (s_axi_araddr[7:2] == iclm_pkg::ADDR_MASK[7:2]) begin
                s_axi_rdata <= {30'h0, mask_reg};
            end else begin
                s_axi_rresp <= iclm_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // millisecond tick for validation
    // ****************************************
    logic [15:0] ms_cnt_reg;
    logic ms_tick;
    assign ms_tick = (ms_cnt_reg == 16'(MS_CYCLES_P - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) begin
            ms_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
    end

    logic [13:0] val_limit;
    always_comb begin
        case (ctrl_reg.clock_validation_time)
            2'h0: val_limit = iclm_pkg::VAL_MS_00;
            2'h1: val_limit = iclm_pkg::VAL_MS_01;
            2'h2: val_limit = iclm_pkg::VAL_MS_10;
            default: val_limit = iclm_pkg::VAL_MS_11;
        endcase
    end

    // ****************************************
    // per-input detector and validation
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_in
            logic s1_reg, s2_reg, s3_reg, lvl_reg, in_edge;
            logic [3:0] div_reg;
            logic mon_edge_reg;
            logic [19:0] idle_reg;
            logic [19:0] window;
            logic [13:0] limit_reg;
            logic [13:0] vcnt_reg;
            logic [1:0] sel;
            iclm_state_t st_reg;

            assign sel = ctrl_reg.loss_detect_select[i];
            // a change counts once stages two and three agree
            assign in_edge = (s2_reg == s3_reg) && (s3_reg != lvl_reg);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= input_clock_n[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    div_reg <= 4'h0;
                    mon_edge_reg <= 1'b0;
                end else begin
                    mon_edge_reg <= 1'b0;
                    if (in_edge) begin
                        div_reg <= div_reg + 4'h1;
                        if (div_reg == iclm_pkg::MON_DIV_LAST) begin
                            div_reg <= 4'h0;
                            mon_edge_reg <= 1'b1;
                        end
                    end
                end
            end

            assign window = (sel == iclm_pkg::SEL_SLOW)
                ? (20'(prediv_reg[i]) << iclm_pkg::SLOW_SHIFT)
                : (20'(prediv_reg[i]) << iclm_pkg::STD_SHIFT);

            always_ff @(posedge aclk) begin
                if (!aresetn || mon_edge_reg) begin
                    idle_reg <= 20'h00000;
                end else if (idle_reg != 20'hfffff) begin
                    idle_reg <= idle_reg + 20'h00001;
                end
            end

            // reserved select code behaves as off
            assign los_raw[i] = (sel[1] == 1'b1)
                && (idle_reg >= window);

            always_ff @(posedge aclk) begin
                if (!aresetn || sel[1] == 1'b0) begin
                    st_reg <= ST_OK;
                    vcnt_reg <= 14'h0000;
                    limit_reg <= iclm_pkg::VAL_MS_00;
                end else begin
                    case (st_reg)
                        ST_OK: begin
                            if (los_raw[i]) begin
                                st_reg <= ST_LOST;
                            end
                        end
                        ST_LOST: begin
                            if (!los_raw[i]) begin
                                st_reg <= ST_VALID;
                                vcnt_reg <= 14'h0000;
                                limit_reg <= val_limit;
                            end
                        end
                        ST_VALID: begin
                            if (los_raw[i]) begin
                                st_reg <= ST_LOST;
                            end else if (ms_tick) begin
                                vcnt_reg <= vcnt_reg + 14'h0001;
                                if (vcnt_reg + 14'h0001 >= limit_reg) begin
                                    st_reg <= ST_OK;
                                end
                            end
                        end
                        default: st_reg <= ST_OK;
                    endcase
                end
            end

            assign loss_alarm[i] = (st_reg != ST_OK);
            assign st_valid[i] = (st_reg == ST_VALID);

            property p_off_quiet;
                @(posedge aclk) disable iff (!aresetn)
                (sel == iclm_pkg::SEL_OFF) |=> !loss_alarm[i];
            endproperty
            a_off_quiet: assert property (p_off_quiet)
                else $error("alarm raised on disabled input");

            property p_edge_clears;
                @(posedge aclk) disable iff (!aresetn)
                (mon_edge_reg && prediv_reg[i] != 16'h0000)
                    |=> !los_raw[i];
            endproperty
            a_edge_clears: assert property (p_edge_clears)
                else $error("loss seen right after an edge");

            property p_restart;
                @(posedge aclk) disable iff (!aresetn)
                (st_valid[i] && los_raw[i] && sel[1])
                    |=> (st_reg == ST_LOST) ##1 !st_valid[i]
                        || vcnt_reg == 14'h0000;
            endproperty
            a_restart: assert property (p_restart)
                else $error("validation not restarted");

            property p_hold_until_valid;
                @(posedge aclk) disable iff (!aresetn)
                ($fell(loss_alarm[i]) && sel[1])
                    |-> $past(st_valid[i]) && $past(ms_tick);
            endproperty
            a_hold_until_valid: assert property (p_hold_until_valid)
                else $error("alarm cleared without validation");
        end
    endgenerate

    // ****************************************
    // alarm pins and interrupt
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_bad_pin <= '0;
            summary_alarm_pin <= 1'b0;
            digital_hold_req <= 1'b0;
            hitless_switch_ok <= 1'b0;
            irq <= 1'b0;
        end else begin
            input_bad_pin <= loss_alarm | freq_offset_alarm;
            summary_alarm_pin <= |(loss_alarm | freq_offset_alarm);
            // disabled inputs add no loss term here
            digital_hold_req <= ctrl_reg.force_digital_hold
                || (|freq_offset_alarm) || (|loss_alarm);
            hitless_switch_ok <= (ctrl_reg.clock_validation_time
                                  != iclm_pkg::VAL_2MS);
            irq <= |(sticky_reg & mask_reg);
        end
    end

    property p_summary;
        @(posedge aclk) disable iff (!aresetn)
        (|loss_alarm) |=> summary_alarm_pin && (|input_bad_pin);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary alarm dropped early");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (|(sticky_reg & mask_reg)) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked sticky without interrupt");

    property p_hitless;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_reg.clock_validation_time == iclm_pkg::VAL_2MS)
            |=> !hitless_switch_ok;
    endproperty
    a_hitless: assert property (p_hitless)
        else $error("hitless allowed at 2 ms validation");

    property p_force_hold;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_reg.force_digital_hold |=> digital_hold_req;
    endproperty
    a_force_hold: assert property (p_force_hold)
        else $error("force hold ignored");

    property p_bresp_hold;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response withdrawn");
endmodule
`default_nettype wire

// ==== test/iclm_ref_clk_model.sv ====
// reference clock sources feeding the monitor's input pins
// assumes the bench gates each source with its own run enable
`default_nettype none
module iclm_ref_clk_model #(
    parameter int HALF_NS = 101
) (
    input wire logic [1:0] run,
    output wire logic [1:0] clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // clock sources
    // ************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_src
        logic lvl = 1'b0;
        // one period for both inputs keeps them well inside 100 ppm
        always #(HALF_NS) lvl = run[i] ? ~lvl : lvl;
        assign clk_out[i] = lvl;
    end
endmodule
`default_nettype wire

// ==== test/iclm_monitor_tb.sv ====
// self-checking bench for the input clock loss monitor
// assumes the reference clock model and a 40 MHz aclk
`default_nettype none
module iclm_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals and instances
    // ************************************************************
    // short ms tick keeps the 100 ms interval near 2000 cycles
    localparam int MS = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    wire logic [1:0] input_clock_n;
    logic [1:0] freq_offset_alarm = 2'h0;
    logic [1:0] input_bad_pin;
    logic summary_alarm_pin;
    logic digital_hold_req;
    logic hitless_switch_ok;
    logic irq;
    // sources run from time zero: a stopped pin would alarm and hold
    // the 100 ms validation before any scenario starts
    logic [1:0] clk_run = 2'h3;
    logic [31:0] rd;
    logic [1:0] rsp;
    int n_mismatch = 0;
    int n_checks = 0;

    always #12.5 aclk = ~aclk;

    iclm_monitor #(.MS_CYCLES_P(MS)) iclm_monitor_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .input_clock_n, .freq_offset_alarm,
        .input_bad_pin, .summary_alarm_pin, .digital_hold_req,
        .hitless_switch_ok, .irq
    );
    iclm_ref_clk_model iclm_ref_clk_model_i (
        .run(clk_run),
        .clk_out(input_clock_n)
    );
    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h", $time, m, got);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        cyc(2);
        chk_bit(hitless_switch_ok, 1'b1, "hitless at reset");
        axi_rd(iclm_pkg::ADDR_CTRL);
        chk_word(rd, 32'h1f, "ctrl reset");
        axi_rd(iclm_pkg::ADDR_PREDIV0);
        chk_word(rd, {16'h0, iclm_pkg::PREDIV_RST}, "prediv reset");
        axi_rd(8'h40);
        chk_word({30'h0, rsp}, 32'h2, "unmapped read");
        axi_wr(8'h40, 32'h0);
        chk_word({30'h0, rsp}, 32'h2, "unmapped write");
        axi_wr(iclm_pkg::ADDR_STATUS, 32'hffff);
        chk_word({30'h0, rsp}, 32'h0, "status write resp");
        axi_rd(iclm_pkg::ADDR_STATUS);
        chk_word(rd, 32'h40, "status read only");
    endtask

    task automatic t_quiet;
        axi_wr(iclm_pkg::ADDR_PREDIV0, 32'h10);
        axi_wr(iclm_pkg::ADDR_PREDIV1, 32'h10);
        axi_wr(iclm_pkg::ADDR_MASK, 32'h3);
        clk_run <= 2'h3;
        cyc(200);
        chk_word({30'h0, input_bad_pin}, 32'h0, "false loss");
        chk_bit(summary_alarm_pin, 1'b0, "false summary");
    endtask

    task automatic t_std;
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h0f);
        cyc(2);
        chk_bit(hitless_switch_ok, 1'b0, "hitless with 2 ms");
        clk_run[0] <= 1'b0;
        cyc(8);
        chk_bit(input_bad_pin[0], 1'b0, "loss too early");
        cyc(50);
        chk_bit(input_bad_pin[0], 1'b1, "loss missed");
        chk_bit(input_bad_pin[1], 1'b0, "loss on other input");
        chk_bit(summary_alarm_pin, 1'b1, "summary missed");
        chk_bit(irq, 1'b1, "irq missed");
        axi_rd(iclm_pkg::ADDR_STATUS);
        chk_word(rd, 32'h195, "status in loss");
        clk_run[0] <= 1'b1;
        cyc(5);
        chk_bit(input_bad_pin[0], 1'b1, "cleared unvalidated");
        cyc(100);
        chk_bit(input_bad_pin[0], 1'b0, "2 ms clear");
        chk_bit(summary_alarm_pin, 1'b0, "summary stuck");
        chk_bit(irq, 1'b1, "sticky lost");
        axi_wr(iclm_pkg::ADDR_STICKY, 32'h1);
        axi_rd(iclm_pkg::ADDR_STICKY);
        chk_word(rd, 32'h0, "sticky clear");
        chk_bit(irq, 1'b0, "irq after clear");
    endtask

    task automatic t_valid;
        logic [31:0] c;
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h1f);
        clk_run[0] <= 1'b0;
        cyc(60);
        clk_run[0] <= 1'b1;
        cyc(1000);
        chk_bit(input_bad_pin[0], 1'b1, "100 ms too short");
        clk_run[0] <= 1'b0;
        cyc(60);
        clk_run[0] <= 1'b1;
        cyc(100);
        // shorter time must wait for the next interval
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h0f);
        cyc(1300);
        chk_bit(input_bad_pin[0], 1'b1, "no restart");
        cyc(800);
        chk_bit(input_bad_pin[0], 1'b0, "100 ms clear");
        for (int v = 0; v < 4; v++) begin
            c = 32'h0f | (v << 4);
            axi_wr(iclm_pkg::ADDR_CTRL, c);
            axi_rd(iclm_pkg::ADDR_CTRL);
            chk_word(rd, c, "clock_validation_time code");
            chk_bit(hitless_switch_ok, v != 0, "hitless code");
        end
    endtask

    task automatic t_slow;
        axi_wr(iclm_pkg::ADDR_MASK, 32'h0);
        axi_wr(iclm_pkg::ADDR_STICKY, 32'h3);
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h1e);
        clk_run[0] <= 1'b0;
        cyc(60);
        chk_bit(input_bad_pin[0], 1'b0, "slow too fast");
        cyc(140);
        chk_bit(input_bad_pin[0], 1'b1, "slow missed");
        chk_bit(irq, 1'b0, "masked irq");
        axi_rd(iclm_pkg::ADDR_STICKY);
        chk_word(rd, 32'h1, "sticky set");
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h1c);
        cyc(3);
        chk_bit(input_bad_pin[0], 1'b0, "off keeps alarm");
        axi_wr(iclm_pkg::ADDR_MASK, 32'h3);
    endtask

    task automatic t_off;
        for (int s = 0; s < 2; s++) begin
            axi_wr(iclm_pkg::ADDR_CTRL, 32'h1c | s);
            cyc(200);
            chk_bit(input_bad_pin[0], 1'b0, "off loss");
            chk_bit(digital_hold_req, 1'b0, "off hold");
        end
        freq_offset_alarm[0] <= 1'b1;
        cyc(3);
        chk_bit(input_bad_pin[0], 1'b1, "offset bad");
        chk_bit(summary_alarm_pin, 1'b1, "offset summary");
        chk_bit(digital_hold_req, 1'b1, "offset hold");
        freq_offset_alarm[0] <= 1'b0;
        axi_wr(iclm_pkg::ADDR_CTRL, 32'h5c);
        cyc(3);
        chk_bit(digital_hold_req, 1'b1, "forced hold");
        chk_bit(summary_alarm_pin, 1'b0, "summary after");
    endtask
    // ************************************************************
    // run control
    // ************************************************************
    task automatic end_sim;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run needs about 4500 cycles
    initial begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_quiet();
        t_std();
        t_valid();
        t_slow();
        t_off();
        end_sim();
    end
endmodule
`default_nettype wire
